// File: dts_consts.svh
// Purpose: offsets, field positions, reset values and codes of the terminal signal block
// Assumes: 32-bit AXI4-Lite register words, frequencies in units of 0.01 Hz
// Notes: definitions only
`ifndef DTS_CONSTS_SVH
`define DTS_CONSTS_SVH
// register byte offsets
`define DTS_OFS_CTRL 8'h00
`define DTS_OFS_LOW_THR 8'h04
`define DTS_OFS_REACH_SET 8'h08
`define DTS_OFS_REACH_BAND 8'h0C
`define DTS_OFS_UPPER 8'h10
`define DTS_OFS_ALWAYS 8'h14
`define DTS_OFS_PIN1_SEL 8'h18
`define DTS_OFS_PIN2_SEL 8'h1C
`define DTS_OFS_TSEL_LO 8'h20
`define DTS_OFS_TSEL_HI 8'h24
`define DTS_OFS_STATUS 8'h28
`define DTS_OFS_IRQ_STAT 8'h2C
`define DTS_OFS_IRQ_EN 8'h30
`define DTS_OFS_IRQ_CLR 8'h34
// control register fields
`define DTS_CTRL_MODE_LSB 0
`define DTS_CTRL_CONFLICT 4
`define DTS_CTRL_OVERRIDE 8
`define DTS_CTRL_STOPPAT 12
// reset values
`define DTS_RST_LOW_THR 16'h0000
`define DTS_RST_REACH_SET 16'h0000
`define DTS_RST_REACH_BAND 16'h00FA
`define DTS_RST_UPPER 16'h1770
`define DTS_RST_ALWAYS 8'h00
`define DTS_RST_PIN1_SEL 8'h04
`define DTS_RST_PIN2_SEL 8'h06
`define DTS_RST_TSEL_LO 32'h08060402
`define DTS_RST_TSEL_HI 32'h100E0C0A
// output selection codes (even normal, odd inverted)
`define DTS_OUT_LOW_SPEED 8'h04
`define DTS_OUT_ACCDEC 8'h06
`define DTS_OUT_REACH 8'h08
`define DTS_OUT_MAX 8'h77
// input function codes (even positive logic, odd negative logic)
`define DTS_FN_FWD 8'h02
`define DTS_FN_REV 8'h04
`define DTS_FN_STANDBY 8'h06
`define DTS_FN_CLEAR 8'h08
`define DTS_FN_PRESET4 8'h10
`define DTS_FN_JOG 8'h12
`define DTS_FN_INJ 8'h16
`define DTS_FN_TERM 8'h30
`define DTS_FN_FJOG_F 8'h32
`define DTS_FN_FJOG_R 8'h34
`define DTS_FN_MAX 8'h87
`endif

// File: dts_pkg.sv
// Purpose: types of the terminal signal block
// Assumes: dts_consts.svh holds all numbers
// Notes: state record is registered whole by the top module
package dts_pkg;
    typedef enum logic [1:0] {
        DTS_SB_STANDARD,
        DTS_SB_ALWAYS,
        DTS_SB_INTERLOCK,
        DTS_SB_SPARE
    } dts_standby_t;
    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [15:0] ctrl;
        logic [15:0] low_thr;
        logic [15:0] reach_set;
        logic [15:0] reach_band;
        logic [15:0] upper;
        logic [7:0] always_sel;
        logic [7:0] pin1_sel;
        logic [7:0] pin2_sel;
        logic [63:0] tsel;
        logic [3:0] flags;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic pin1;
        logic pin2;
        logic [9:0] cmd;
    } dts_state_t;
endpackage

// File: dts_terminal_signal.sv
// Purpose: speed flags, collector outputs and input terminal decode
// Assumes: out_freq, ramp_active on sys_clk; term_pins raw contacts, 1 = closed
// Notes: settings over AXI4-Lite; state is one packed record
`timescale 1ns/1ps
`default_nettype none
`include "dts_consts.svh"

// Operation
// - low-speed flag when frequency above threshold
// - low-speed on collector 1, codes 4/5
// - reach flag inside setpoint plus/minus band
// - reach flag selectable on collector 2
// - standard standby needs hold input closed
// - always-on standby ignores hold input
// - always-on standby stops by deceleration
// - interlocked standby runs while direction closed
// - both directions: reverse or decel stop
// - panel wins until terminal switchover
// - priority lets terminal overrides beat panel
// - brake/forced jog override ignored when stop pattern 1
// - one function selectable as always active
// - each terminal picks code, aux four 16
// - ramp completion flag, inverted code 7
module dts_terminal_signal (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // terminal contacts: 0 fwd,1 rev,2 hold gate,3 clear fault,4..7 aux 1..4
    input wire logic [7:0] term_pins,
    input wire logic [15:0] out_freq,
    input wire logic ramp_active,
    input wire logic panel_run,
    input wire logic panel_reverse,
    output logic collector_pin_1,
    output logic collector_pin_2,
    output logic run_cmd,
    output logic reverse_cmd,
    output logic gate_enable,
    output logic decel_stop,
    output logic jog_cmd,
    output logic inj_brake_cmd,
    output logic forced_jog_fwd,
    output logic forced_jog_rev,
    output logic terminal_mode,
    output logic preset_bit4,
    output logic clear_fault,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ************************************************************
    // state record
    // ************************************************************
    dts_pkg::dts_state_t s_q; // all registered state
    dts_pkg::dts_state_t s_d; // next value

    // ************************************************************
    // helpers
    // ************************************************************
    // fn is on: positive-logic terminal closed,
    // negative-logic terminal open, or fn always active
    function automatic logic fn_on(input logic [7:0] fn, input logic [7:0] pins,
                                   input logic [63:0] tsel, input logic [7:0] alw);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (tsel[i*8 +: 8] == fn && pins[i]) begin
                hit = 1'b1;
            end
            if (tsel[i*8 +: 8] == (fn | 8'h01) && !pins[i]) begin
                hit = 1'b1;
            end
        end
        // code polarity ignored for the always active choice
        if ((alw & 8'hFE) == fn) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // drive level of a collector for a selection code; odd codes 5, 7 and 9 invert
    function automatic logic pin_drive(input logic [7:0] code, input logic [3:0] fl);
        logic v;
        v = 1'b0;
        case (code & 8'hFE)
            `DTS_OUT_LOW_SPEED: begin
                v = fl[0];
            end
            `DTS_OUT_REACH: begin
                v = fl[1];
            end
            `DTS_OUT_ACCDEC: begin
                v = fl[2];
            end
            default: begin
                v = 1'b0;
            end
        endcase
        // inverted form is active while the flag is false
        if (code[0] && code >= `DTS_OUT_LOW_SPEED && code <= (`DTS_OUT_REACH | 8'h01)) begin
            v = !v;
        end
        return v;
    endfunction

    // byte strobe merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // frequency settings never exceed the upper limit
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] ul);
        return (v > ul) ? ul : v;
    endfunction

    // ************************************************************
    // combinational next state
    // ************************************************************
    // decoded terminal functions
    logic fwd_t, rev_t, hold_t, term_t, jog_t, inj_t, fjf_t, fjr_t;
    // working signals
    logic [16:0] reach_lo, reach_hi;
    logic [3:0] fl_new, ev;
    logic [31:0] wword, rword;
    logic [15:0] wv16;
    logic conflict, prio, pat1, stand_ok, t_run, t_rev, coast;
    logic do_write, wr_err, rd_err;
    logic [3:0] irq_clr;
    dts_pkg::dts_standby_t sb_mode;

    always_comb begin
        s_d = s_q;
        // synchroniser: second stage only is read by the logic below
        s_d.sync1 = term_pins;
        s_d.sync2 = s_q.sync1;
        sb_mode = dts_pkg::dts_standby_t'(s_q.ctrl[`DTS_CTRL_MODE_LSB +: 2]);
        fwd_t = fn_on(`DTS_FN_FWD, s_q.sync2, s_q.tsel, s_q.always_sel);
        rev_t = fn_on(`DTS_FN_REV, s_q.sync2, s_q.tsel, s_q.always_sel);
        hold_t = fn_on(`DTS_FN_STANDBY, s_q.sync2, s_q.tsel, s_q.always_sel);
        term_t = fn_on(`DTS_FN_TERM, s_q.sync2, s_q.tsel, s_q.always_sel);
        jog_t = fn_on(`DTS_FN_JOG, s_q.sync2, s_q.tsel, s_q.always_sel);
        inj_t = fn_on(`DTS_FN_INJ, s_q.sync2, s_q.tsel, s_q.always_sel);
        fjf_t = fn_on(`DTS_FN_FJOG_F, s_q.sync2, s_q.tsel, s_q.always_sel);
        fjr_t = fn_on(`DTS_FN_FJOG_R, s_q.sync2, s_q.tsel, s_q.always_sel);
        prio = s_q.ctrl[`DTS_CTRL_OVERRIDE];
        pat1 = s_q.ctrl[`DTS_CTRL_STOPPAT];

        // ---- frequency flags, recomputed every enabled cycle ----
        reach_lo = {1'b0, s_q.reach_set} - {1'b0, s_q.reach_band};
        reach_hi = {1'b0, s_q.reach_set} + {1'b0, s_q.reach_band};
        // a band wider than the setpoint saturates the low edge at zero
        if (s_q.reach_band > s_q.reach_set) begin
            reach_lo = 17'h00000;
        end
        fl_new[0] = out_freq > s_q.low_thr;
        fl_new[1] = ({1'b0, out_freq} >= reach_lo) && ({1'b0, out_freq} <= reach_hi);
        fl_new[2] = !ramp_active;

        // ---- direction and standby ----
        conflict = fwd_t && rev_t;
        fl_new[3] = conflict;
        t_run = fwd_t || rev_t;
        t_rev = rev_t;
        if (conflict && s_q.ctrl[`DTS_CTRL_CONFLICT]) begin
            t_run = 1'b0;
        end else if (conflict) begin
            t_rev = 1'b1;
        end
        case (sb_mode)
            dts_pkg::DTS_SB_STANDARD: begin
                stand_ok = hold_t;
                coast = !hold_t;
            end
            dts_pkg::DTS_SB_ALWAYS: begin
                stand_ok = 1'b1;
                coast = 1'b0;
            end
            dts_pkg::DTS_SB_INTERLOCK: begin
                stand_ok = fwd_t || rev_t;
                coast = !(fwd_t || rev_t);
            end
            default: begin
                stand_ok = hold_t;
                coast = !hold_t;
            end
        endcase

        // ---- command source: panel until a terminal switches over ----
        if (term_t) begin
            s_d.cmd[0] = t_run && stand_ok;
            s_d.cmd[1] = t_rev;
        end else begin
            s_d.cmd[0] = panel_run && stand_ok;
            s_d.cmd[1] = panel_reverse;
        end
        s_d.cmd[2] = stand_ok && !coast; // gate on
        // a stop that does not coast ramps down
        s_d.cmd[3] = !s_d.cmd[0] && !coast;
        s_d.cmd[4] = jog_t && (term_t || prio);
        s_d.cmd[5] = inj_t && (term_t || (prio && !pat1));
        s_d.cmd[6] = fjf_t && (term_t || (prio && !pat1));
        s_d.cmd[7] = fjr_t && (term_t || (prio && !pat1));
        s_d.cmd[8] = term_t;
        s_d.cmd[9] = fn_on(`DTS_FN_PRESET4, s_q.sync2, s_q.tsel, s_q.always_sel);

        // ---- collectors and events ----
        s_d.flags = fl_new;
        s_d.pin1 = pin_drive(s_q.pin1_sel, fl_new);
        s_d.pin2 = pin_drive(s_q.pin2_sel, fl_new);
        ev = fl_new & ~s_q.flags; // rising edges only

        // ---- AXI write channel ----
        if (s_axi_awvalid && !s_q.aw_held && !s_q.bvalid) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_held && !s_q.bvalid) begin
            s_d.w_held = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;
        wword = 32'h00000000;
        wv16 = 16'h0000;
        wr_err = 1'b0;
        irq_clr = 4'h0;
        if (do_write) begin
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.bvalid = 1'b1;
            case ({s_q.aw_addr[7:2], 2'b00})
                `DTS_OFS_CTRL: begin
                    wword = merge({16'h0000, s_q.ctrl}, s_q.w_data, s_q.w_strb);
                    s_d.ctrl = wword[15:0] & 16'h1113;
                end
                `DTS_OFS_LOW_THR: begin
                    wword = merge({16'h0000, s_q.low_thr}, s_q.w_data, s_q.w_strb);
                    s_d.low_thr = clamp(wword[15:0], s_q.upper);
                end
                `DTS_OFS_REACH_SET: begin
                    wword = merge({16'h0000, s_q.reach_set}, s_q.w_data, s_q.w_strb);
                    s_d.reach_set = clamp(wword[15:0], s_q.upper);
                end
                `DTS_OFS_REACH_BAND: begin
                    wword = merge({16'h0000, s_q.reach_band}, s_q.w_data, s_q.w_strb);
                    s_d.reach_band = clamp(wword[15:0], s_q.upper);
                end
                `DTS_OFS_UPPER: begin
                    wword = merge({16'h0000, s_q.upper}, s_q.w_data, s_q.w_strb);
                    wv16 = wword[15:0];
                    s_d.upper = wv16;
                    // a lower limit pulls the settings down
                    s_d.low_thr = clamp(s_q.low_thr, wv16);
                    s_d.reach_set = clamp(s_q.reach_set, wv16);
                    s_d.reach_band = clamp(s_q.reach_band, wv16);
                end
                `DTS_OFS_ALWAYS: begin
                    wword = merge({24'h000000, s_q.always_sel}, s_q.w_data, s_q.w_strb);
                    if (wword[7:0] <= `DTS_FN_MAX) begin
                        s_d.always_sel = wword[7:0];
                    end
                end
                `DTS_OFS_PIN1_SEL: begin
                    wword = merge({24'h000000, s_q.pin1_sel}, s_q.w_data, s_q.w_strb);
                    if (wword[7:0] <= `DTS_OUT_MAX) begin
                        s_d.pin1_sel = wword[7:0];
                    end
                end
                `DTS_OFS_PIN2_SEL: begin
                    wword = merge({24'h000000, s_q.pin2_sel}, s_q.w_data, s_q.w_strb);
                    if (wword[7:0] <= `DTS_OUT_MAX) begin
                        s_d.pin2_sel = wword[7:0];
                    end
                end
                `DTS_OFS_TSEL_LO: begin
                    wword = merge(s_q.tsel[31:0], s_q.w_data, s_q.w_strb);
                    for (int k = 0; k < 4; k++) begin
                        if (wword[k*8 +: 8] <= `DTS_FN_MAX) begin
                            s_d.tsel[k*8 +: 8] = wword[k*8 +: 8];
                        end
                    end
                end
                `DTS_OFS_TSEL_HI: begin
                    wword = merge(s_q.tsel[63:32], s_q.w_data, s_q.w_strb);
                    for (int k = 0; k < 4; k++) begin
                        if (wword[k*8 +: 8] <= `DTS_FN_MAX) begin
                            s_d.tsel[32 + k*8 +: 8] = wword[k*8 +: 8];
                        end
                    end
                end
                `DTS_OFS_IRQ_EN: begin
                    s_d.irq_en = s_q.w_strb[0] ? s_q.w_data[3:0] : s_q.irq_en;
                end
                `DTS_OFS_IRQ_CLR: begin
                    irq_clr = s_q.w_strb[0] ? s_q.w_data[3:0] : 4'h0;
                end
                `DTS_OFS_STATUS, `DTS_OFS_IRQ_STAT: begin
                    wr_err = 1'b0; // read only, write ignored
                end
                default: begin
                    wr_err = 1'b1; // unmapped
                end
            endcase
            s_d.bresp = wr_err ? 2'b10 : 2'b00;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // sticky events: a new event beats a clear in the same cycle
        s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | ev;

        // ---- AXI read channel ----
        rword = 32'h00000000;
        rd_err = 1'b0;
        case ({s_axi_araddr[7:2], 2'b00})
            `DTS_OFS_CTRL: rword = {16'h0000, s_q.ctrl};
            `DTS_OFS_LOW_THR: rword = {16'h0000, s_q.low_thr};
            `DTS_OFS_REACH_SET: rword = {16'h0000, s_q.reach_set};
            `DTS_OFS_REACH_BAND: rword = {16'h0000, s_q.reach_band};
            `DTS_OFS_UPPER: rword = {16'h0000, s_q.upper};
            `DTS_OFS_ALWAYS: rword = {24'h000000, s_q.always_sel};
            `DTS_OFS_PIN1_SEL: rword = {24'h000000, s_q.pin1_sel};
            `DTS_OFS_PIN2_SEL: rword = {24'h000000, s_q.pin2_sel};
            `DTS_OFS_TSEL_LO: rword = s_q.tsel[31:0];
            `DTS_OFS_TSEL_HI: rword = s_q.tsel[63:32];
            `DTS_OFS_STATUS: rword = {12'h000, s_q.cmd, s_q.pin2, s_q.pin1, 4'h0, s_q.flags};
            `DTS_OFS_IRQ_STAT: rword = {28'h0000000, s_q.irq_stat};
            `DTS_OFS_IRQ_EN: rword = {28'h0000000, s_q.irq_en};
            `DTS_OFS_IRQ_CLR: rword = 32'h00000000; // write only
            default: rd_err = 1'b1;
        endcase
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rword;
            s_d.rresp = rd_err ? 2'b10 : 2'b00;
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    // reset loads constants only; clock enable low freezes everything
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.reach_band <= `DTS_RST_REACH_BAND;
            s_q.low_thr <= `DTS_RST_LOW_THR;
            s_q.reach_set <= `DTS_RST_REACH_SET;
            s_q.upper <= `DTS_RST_UPPER;
            s_q.always_sel <= `DTS_RST_ALWAYS;
            s_q.pin1_sel <= `DTS_RST_PIN1_SEL;
            s_q.pin2_sel <= `DTS_RST_PIN2_SEL;
            s_q.tsel <= {`DTS_RST_TSEL_HI, `DTS_RST_TSEL_LO};
            s_q.flags <= 4'h4;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign collector_pin_1 = s_q.pin1;
    assign collector_pin_2 = s_q.pin2;
    assign run_cmd = s_q.cmd[0];
    assign reverse_cmd = s_q.cmd[1];
    assign gate_enable = s_q.cmd[2];
    assign decel_stop = s_q.cmd[3];
    assign jog_cmd = s_q.cmd[4];
    assign inj_brake_cmd = s_q.cmd[5];
    assign forced_jog_fwd = s_q.cmd[6];
    assign forced_jog_rev = s_q.cmd[7];
    assign terminal_mode = s_q.cmd[8];
    assign preset_bit4 = s_q.cmd[9];
    assign clear_fault = fn_on(`DTS_FN_CLEAR, s_q.sync2, s_q.tsel, s_q.always_sel);
    // level interrupt while any enabled sticky bit is set
    assign irq = |(s_q.irq_stat & s_q.irq_en);
    // a channel is ready only while its holding slot is empty
    assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
endmodule
`default_nettype wire

// File: dts_terminal_signal_props.sv
// Purpose: bus and interrupt timing checks at the block's ports
// Assumes: clk_en held high by the bench
// Notes: bound to every dts_terminal_signal instance
`timescale 1ns/1ps
`default_nettype none
module dts_terminal_signal_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic irq,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ****************
    // handshake timing
    // ****************
    sequence s_both; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_resp; !s_axi_bvalid ##1 s_axi_bvalid; endsequence
    property p_wr_late; s_both |=> s_resp; endproperty
    a_wr_late: assert property (p_wr_late) else $error("write answer off time");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_b_end; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_end: assert property (p_b_end) else $error("write answer stuck");
    property p_w_shut; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_w_shut: assert property (p_w_shut) else $error("write taken during answer");
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data moved");
    property p_r_end; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_end: assert property (p_r_end) else $error("read answer stuck");
    property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_ar: assert property (p_ar) else $error("read taken during answer");
    // sticky status only drops through a committed write
    property p_irq; $fell(irq) |-> $rose(s_axi_bvalid); endproperty
    a_irq: assert property (p_irq) else $error("interrupt fell without write");
endmodule
bind dts_terminal_signal dts_terminal_signal_props u_props (.*);
`default_nettype wire

// File: dts_contacts_model.sv
// Purpose: external contacts and panel keys
// Assumes: bench asks for a contact set
// Notes: contacts move one edge after the ask
`timescale 1ns/1ps
`default_nettype none
module dts_contacts_model (
    input wire logic sys_clk,
    input wire logic [9:0] want,
    output logic [7:0] term_pins,
    output logic panel_run,
    output logic panel_reverse
);
    always_ff @(posedge sys_clk) begin
        {panel_reverse, panel_run, term_pins} <= want;
    end
endmodule
`default_nettype wire

// File: drive_terminal_signal_logic_bench.sv
// Purpose: self-checking bench of the terminal signal block
// Assumes: clk_en tied high
// Notes: outputs judged after the sync delay
`timescale 1ns/1ps
`default_nettype none
module drive_terminal_signal_logic_bench;
    logic sys_clk = 1'b0, rst = 1'b1, ramp = 1'b1;
    logic [9:0] want = 10'h004;
    logic [15:0] freq = 16'h0000;
    logic [7:0] pins, awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic prun, prev, p1, p2, run, rev, gate, dstop, irq, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int n_fail = 0, n_checks = 0;
    always #25 sys_clk = ~sys_clk;
    dts_contacts_model u_model (.sys_clk(sys_clk), .want(want), .term_pins(pins), .panel_run(prun),
        .panel_reverse(prev));
    dts_terminal_signal u_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .term_pins(pins),
        .out_freq(freq), .ramp_active(ramp), .panel_run(prun), .panel_reverse(prev),
        .collector_pin_1(p1), .collector_pin_2(p2), .run_cmd(run), .reverse_cmd(rev), .gate_enable(gate),
        .decel_stop(dstop), .jog_cmd(), .inj_brake_cmd(), .forced_jog_fwd(), .forced_jog_rev(),
        .terminal_mode(), .preset_bit4(), .clear_fault(), .irq(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, hb = 1'b0;
        int i;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 50 && !hb; i++) begin
            @(negedge sys_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            hb = bvalid;
            @(posedge sys_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (hb) bready <= 1'b0;
        end
        if (!hb) begin
            n_fail++;
            report_and_stop();
        end
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ta, hb = 1'b0;
        int i;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 50 && !hb; i++) begin
            @(negedge sys_clk);
            ta = arvalid && arready;
            hb = rvalid;
            @(posedge sys_clk);
            if (ta) arvalid <= 1'b0;
            if (hb) rready <= 1'b0;
        end
        if (!hb) begin
            n_fail++;
            report_and_stop();
        end
        chk(rdata, exp);
        chk(32'(rresp), 32'(er));
    endtask
    // 4 edges of latency, 5 for margin
    task automatic drive(input logic [9:0] v, input logic [15:0] f, input logic r);
        @(posedge sys_clk);
        want <= v;
        freq <= f;
        ramp <= r;
        repeat (5) @(posedge sys_clk);
        #1;
    endtask
    task automatic test_regs();
        rd(8'h18, 32'h4, 2'h0);
        rd(8'h04, 32'h0, 2'h0);
        rd(8'h14, 32'h0, 2'h0);
        rd(8'h24, 32'h100E0C0A, 2'h0);
        rd(8'h40, 32'h0, 2'h2);
        wr(8'h40, 32'h1, 2'h2);
        $display("test_regs ended");
    endtask
    task automatic test_flags();
        wr(8'h30, 32'h1, 2'h0);
        wr(8'h04, 32'h3E8, 2'h0);
        drive(10'h004, 16'h03E8, 1'b1);
        chk(32'(p1), 32'h0);
        drive(10'h004, 16'h03E9, 1'b1);
        chk(32'(p1), 32'h1);
        chk(32'(irq), 32'h1);
        wr(8'h34, 32'h1, 2'h0);
        wr(8'h18, 32'h5, 2'h0);
        wr(8'h18, 32'h78, 2'h0);
        rd(8'h18, 32'h5, 2'h0);
        drive(10'h004, 16'h03E9, 1'b1);
        chk(32'(irq), 32'h0);
        chk(32'(p1), 32'h0);
        wr(8'h1C, 32'h8, 2'h0);
        wr(8'h08, 32'h7D0, 2'h0);
        wr(8'h0C, 32'h64, 2'h0);
        drive(10'h004, 16'h0800, 1'b1);
        chk(32'(p2), 32'h1);
        drive(10'h004, 16'h0900, 1'b1);
        chk(32'(p2), 32'h0);
        wr(8'h1C, 32'h7, 2'h0);
        drive(10'h004, 16'h0900, 1'b0);
        chk(32'(p2), 32'h0);
        $display("test_flags ended");
    endtask
    task automatic test_terminal();
        wr(8'h24, 32'h100E0C30, 2'h0);
        drive(10'h005, 16'h0000, 1'b1);
        chk(32'(run), 32'h0);
        drive(10'h015, 16'h0000, 1'b1);
        chk(32'(run), 32'h1);
        drive(10'h017, 16'h0000, 1'b1);
        chk({30'h0, run, rev}, 32'h3);
        wr(8'h00, 32'h10, 2'h0);
        drive(10'h017, 16'h0000, 1'b1);
        chk({30'h0, run, dstop}, 32'h1);
        wr(8'h00, 32'h0, 2'h0);
        drive(10'h010, 16'h0000, 1'b1);
        chk(32'(gate), 32'h0);
        wr(8'h00, 32'h1, 2'h0);
        drive(10'h010, 16'h0000, 1'b1);
        chk(32'(gate), 32'h1);
        wr(8'h00, 32'h2, 2'h0);
        drive(10'h011, 16'h0000, 1'b1);
        chk(32'(gate), 32'h1);
        $display("test_terminal ended");
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        test_regs();
        test_flags();
        test_terminal();
        report_and_stop();
    end
endmodule
`default_nettype wire
